// File: hw/srcu_pkg.sv
// Purpose: shared constants and types of the status reporting command unit
// Assumes: 8-bit status registers, one response byte per handshake
// Notes: command codes are a flat binary space decoded by the main module
`default_nettype none
package srcu_pkg;
   // response framing
   localparam logic [7:0] TERM_CHAR = 8'h0a;  // response terminator
   localparam logic [7:0] ASCII_ZERO = 8'h30;
   localparam logic [7:0] ASCII_ONE = 8'h31;
   localparam logic [7:0] REG_RST = 8'h00;     // reset value of every status register
   // event status register bit positions
   localparam int ESR_OPC_BIT = 0;
   localparam int ESR_QYE_BIT = 2;
   localparam int ESR_EXE_BIT = 4;
   localparam int ESR_CME_BIT = 5;
   // status byte bit positions
   localparam int STB_MAV_BIT = 4;
   localparam int STB_ESB_BIT = 5;
   localparam int STB_MSS_BIT = 6;
   // command codes
   localparam logic [4:0] CMD_CLS = 5'h00;
   localparam logic [4:0] CMD_ESE_W = 5'h01;
   localparam logic [4:0] CMD_ESE_Q = 5'h02;
   localparam logic [4:0] CMD_ESR_Q = 5'h03;
   localparam logic [4:0] CMD_OPC = 5'h04;
   localparam logic [4:0] CMD_OPC_Q = 5'h05;
   localparam logic [4:0] CMD_IDN_Q = 5'h06;
   localparam logic [4:0] CMD_IST_Q = 5'h07;
   localparam logic [4:0] CMD_PRE_W = 5'h08;
   localparam logic [4:0] CMD_PRE_Q = 5'h09;
   localparam logic [4:0] CMD_SRE_W = 5'h0a;
   localparam logic [4:0] CMD_SRE_Q = 5'h0b;
   localparam logic [4:0] CMD_STB_Q = 5'h0c;
   localparam logic [4:0] CMD_WAI = 5'h0d;
   localparam logic [4:0] CMD_TST_Q = 5'h0e;
   localparam logic [4:0] CMD_EXEC_ERR_Q = 5'h0f;  // execution_error_query
   localparam logic [4:0] CMD_QUERY_ERR_Q = 5'h10; // query_error_query
   localparam logic [4:0] CMD_FORCE_TRG = 5'h11;   // forced_trigger_command
   // trigger source selection
   localparam logic [2:0] TRIG_SRC_MAN = 3'h2;
   // response sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_NUM = 3'b010,
      ST_ID = 3'b100
   } srcu_state_t;
   typedef struct packed {
      srcu_state_t st;
      logic [7:0] ese;
      logic [7:0] esr;
      logic [7:0] sre;
      logic [7:0] pre;
      logic [7:0] stb;
      logic [7:0] eer;
      logic [7:0] qer;
      logic [31:0] sbuf;
      logic [2:0] len;
      logic [5:0] addr;
      logic rv;
      logic [7:0] rd;
      logic rl;
      logic cr;
      logic trg;
      logic srq;
      logic ist;
   } srcu_regs_t;
endpackage
`default_nettype wire

// File: hw/srcu_dec_fmt.sv
// Purpose: turn an 8-bit value into left-justified ascii decimal plus terminator
// Assumes: value 0..255, so at most three digits
// Notes: purely combinational; the caller registers the result
`default_nettype none
module srcu_dec_fmt (
   input wire logic [7:0] val_i,
   output logic [31:0] str_o,
   output logic [2:0] len_o
);
   logic [7:0] hun;
   logic [7:0] ten;
   logic [7:0] one;
   // split into digits; division by constants folds into small logic
   always_comb begin
      hun = val_i / 8'h64;
      ten = (val_i / 8'h0a) % 8'h0a;
      one = val_i % 8'h0a;
      if (hun != 8'h00) begin
         str_o = {srcu_pkg::ASCII_ZERO + hun, srcu_pkg::ASCII_ZERO + ten, srcu_pkg::ASCII_ZERO + one,
                  srcu_pkg::TERM_CHAR};
         len_o = 3'h4;
      end else if (ten != 8'h00) begin
         str_o = {srcu_pkg::ASCII_ZERO + ten, srcu_pkg::ASCII_ZERO + one, srcu_pkg::TERM_CHAR, 8'h00};
         len_o = 3'h3;
      end else begin
         str_o = {srcu_pkg::ASCII_ZERO + one, srcu_pkg::TERM_CHAR, 16'h0000};
         len_o = 3'h2;
      end
   end
endmodule // srcu_dec_fmt
`default_nettype wire

// File: hw/srcu_id_rom.sv
// Purpose: identification text store with registered read data
// Assumes: text holds maker, model, zero and revision separated by commas
// Notes: any address at or past the text end reads the terminator
`default_nettype none
module srcu_id_rom #(
   parameter int ID_LEN = 21,
   // arbitrary neutral identification text
   parameter logic [8*ID_LEN-1:0] ID_TEXT = "ACMECO,WAVEGEN,0,1.00"
) (
   input wire logic clk_sys_i,
   input wire logic [5:0] addr_i,
   output logic [7:0] data_o
);
   logic [7:0] data_d;
   logic [7:0] data_q;
   // text must fit the address space with one slot left for the terminator
   if (ID_LEN < 1 || ID_LEN > 63) begin : g_len_chk
      $error("srcu_id_rom: ID_LEN out of range");
   end
   // byte lookup; beyond the text comes the terminator
   always_comb begin
      if (int'(addr_i) < ID_LEN) begin
         data_d = ID_TEXT[8*(ID_LEN-1-int'(addr_i)) +: 8];
      end else begin
         data_d = srcu_pkg::TERM_CHAR;
      end
   end
   // read register; no reset needed, data is only used after a fetch
   always_ff @(posedge clk_sys_i) begin
      data_q <= data_d;
   end
   assign data_o = data_q;
endmodule // srcu_id_rom
`default_nettype wire

// File: hw/srcu_top.sv
// Purpose: status, event and error reporting part of a remote command interpreter
// Assumes: the parser delivers decoded command codes with an 8-bit argument
// Notes: responses are ascii bytes on a valid/ready stream ending with the terminator
`default_nettype none
// Behaviour
// - clear-status empties the event status, query error and execution error registers, and so the status byte.
// - event-status-enable write loads the enable register with the argument.
// - event-status-enable query returns the enable register in decimal with terminator.
// - event-status query returns the event status register in decimal and then clears it.
// - operation-complete sets bit 0 of the event status register at once.
// - operation-complete query answers 1 with terminator straight away.
// - identification query returns maker, model, a zero and revision, comma separated.
// - individual-status query returns 0 or 1 from the local status message with terminator.
// - parallel poll enable register is loaded by a write and returned by a query in decimal.
// - service request enable register is loaded by a write and returned by a query in decimal.
// - status-byte query returns the status byte in decimal with terminator.
// - each command finishes before the next is taken, so wait-for-completion does nothing.
// - self-test query always answers 0 with terminator.
// - execution-error query returns the execution error number and clears it.
// - query-error query returns the query error number and clears it.
// - forced trigger fires a trigger unless the manual source is selected.
module srcu_top (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic cmd_valid_i,
   input wire logic [4:0] cmd_code_i,
   input wire logic [7:0] cmd_arg_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [7:0] rsp_data_o,
   output logic rsp_last_o,
   input wire logic rsp_ready_i,
   input wire logic [7:0] evt_set_i,
   input wire logic exec_err_i,
   input wire logic [7:0] exec_err_num_i,
   input wire logic query_err_i,
   input wire logic [7:0] query_err_num_i,
   input wire logic [2:0] trig_src_i,
   output logic trig_o,
   output logic [7:0] esr_o,
   output logic [7:0] stb_o,
   output logic srq_o,
   output logic ist_o
);
   srcu_pkg::srcu_regs_t s_q;
   srcu_pkg::srcu_regs_t s_d;
   logic take;
   logic free;
   logic clr_esr;
   logic [7:0] set_esr;
   logic [7:0] num_v;
   logic num_go;
   logic [31:0] num_str;
   logic [2:0] num_len;
   logic [7:0] rom_data;
   logic [7:0] base_stb;

   // value to be formatted for whichever numeric query is presented
   always_comb begin
      num_go = 1'b1;
      case (cmd_code_i)
         srcu_pkg::CMD_ESE_Q: num_v = s_q.ese;
         srcu_pkg::CMD_ESR_Q: num_v = s_q.esr;
         srcu_pkg::CMD_OPC_Q: num_v = 8'h01;
         srcu_pkg::CMD_IST_Q: num_v = {7'h00, s_q.ist};
         srcu_pkg::CMD_PRE_Q: num_v = s_q.pre;
         srcu_pkg::CMD_SRE_Q: num_v = s_q.sre;
         srcu_pkg::CMD_STB_Q: num_v = s_q.stb;
         srcu_pkg::CMD_TST_Q: num_v = 8'h00;
         srcu_pkg::CMD_EXEC_ERR_Q: num_v = s_q.eer;
         srcu_pkg::CMD_QUERY_ERR_Q: num_v = s_q.qer;
         default: begin
            num_v = 8'h00;
            num_go = 1'b0;
         end
      endcase
   end

   srcu_dec_fmt u_fmt (
      .val_i(num_v),
      .str_o(num_str),
      .len_o(num_len)
   );

   srcu_id_rom u_rom (
      .clk_sys_i(clk_sys_i),
      .addr_i(s_d.addr),
      .data_o(rom_data)
   );

   // next state: command decode, event capture, response sequencing
   always_comb begin
      s_d = s_q;
      s_d.trg = 1'b0;
      clr_esr = 1'b0;
      set_esr = evt_set_i;
      set_esr[srcu_pkg::ESR_EXE_BIT] = evt_set_i[srcu_pkg::ESR_EXE_BIT] | exec_err_i;
      set_esr[srcu_pkg::ESR_QYE_BIT] = evt_set_i[srcu_pkg::ESR_QYE_BIT] | query_err_i;
      take = cmd_valid_i && s_q.cr; // only taken when idle
      free = !s_q.rv || rsp_ready_i;
      if (take) begin
         if (num_go) begin
            s_d.st = srcu_pkg::ST_NUM;
            s_d.sbuf = num_str;
            s_d.len = num_len;
         end
         case (cmd_code_i)
            srcu_pkg::CMD_CLS: begin
               clr_esr = 1'b1;
               s_d.eer = srcu_pkg::REG_RST;
               s_d.qer = srcu_pkg::REG_RST;
            end
            srcu_pkg::CMD_ESE_W: s_d.ese = cmd_arg_i;
            srcu_pkg::CMD_ESR_Q: clr_esr = 1'b1; // read then clear
            srcu_pkg::CMD_OPC: set_esr[srcu_pkg::ESR_OPC_BIT] = 1'b1;
            srcu_pkg::CMD_IDN_Q: begin
               s_d.st = srcu_pkg::ST_ID;
               s_d.addr = 6'h00;
            end
            srcu_pkg::CMD_PRE_W: s_d.pre = cmd_arg_i;
            srcu_pkg::CMD_SRE_W: s_d.sre = cmd_arg_i;
            srcu_pkg::CMD_EXEC_ERR_Q: s_d.eer = srcu_pkg::REG_RST;
            srcu_pkg::CMD_QUERY_ERR_Q: s_d.qer = srcu_pkg::REG_RST;
            srcu_pkg::CMD_FORCE_TRG: s_d.trg = (trig_src_i != srcu_pkg::TRIG_SRC_MAN);
            srcu_pkg::CMD_WAI: s_d.cr = 1'b1; // nothing left to wait
            default: begin
               // unknown code flags a command error; queries are handled above
               if (!num_go) begin
                  set_esr[srcu_pkg::ESR_CME_BIT] = 1'b1;
               end
            end
         endcase
      end
      // new errors win over a read-clear in the same cycle
      if (exec_err_i) begin
         s_d.eer = exec_err_num_i;
      end
      if (query_err_i) begin
         s_d.qer = query_err_num_i;
      end
      s_d.esr = (clr_esr ? srcu_pkg::REG_RST : s_q.esr) | set_esr;
      // output slot: one byte stands until the host takes it
      if (free) begin
         s_d.rv = 1'b0;
      end
      case (s_q.st)
         srcu_pkg::ST_IDLE: begin
         end
         srcu_pkg::ST_NUM: begin
            if (free) begin
               s_d.rv = 1'b1;
               s_d.rd = s_q.sbuf[31:24];
               s_d.rl = (s_q.len == 3'h1);
               s_d.sbuf = {s_q.sbuf[23:0], 8'h00};
               s_d.len = s_q.len - 3'h1;
               if (s_q.len == 3'h1) begin
                  s_d.st = srcu_pkg::ST_IDLE;
               end
            end
         end
         srcu_pkg::ST_ID: begin
            if (free) begin
               s_d.rv = 1'b1;
               s_d.rd = rom_data;
               s_d.rl = (rom_data == srcu_pkg::TERM_CHAR);
               s_d.addr = s_q.addr + 6'h01;
               if (rom_data == srcu_pkg::TERM_CHAR) begin
                  s_d.st = srcu_pkg::ST_IDLE;
               end
            end
         end
         default: s_d.st = srcu_pkg::ST_IDLE;
      endcase
      s_d.cr = (s_d.st == srcu_pkg::ST_IDLE);
      // status byte is derived, so clearing its sources clears it too
      base_stb = 8'h00;
      base_stb[srcu_pkg::STB_ESB_BIT] = |(s_d.esr & s_d.ese);
      base_stb[srcu_pkg::STB_MAV_BIT] = s_d.rv || (s_d.st != srcu_pkg::ST_IDLE);
      s_d.srq = |(base_stb & s_d.sre);
      s_d.stb = base_stb;
      s_d.stb[srcu_pkg::STB_MSS_BIT] = s_d.srq;
      s_d.ist = |(s_d.stb & s_d.pre); // local status message from the poll mask
   end

   // state register
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.st <= srcu_pkg::ST_IDLE;
         s_q.cr <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign cmd_ready_o = s_q.cr;
   assign rsp_valid_o = s_q.rv;
   assign rsp_data_o = s_q.rd;
   assign rsp_last_o = s_q.rl;
   assign trig_o = s_q.trg;
   assign esr_o = s_q.esr;
   assign stb_o = s_q.stb;
   assign srq_o = s_q.srq;
   assign ist_o = s_q.ist;

   // checks
   property p_cls;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_CLS && evt_set_i == 8'h00
         && !exec_err_i && !query_err_i |=> esr_o == 8'h00 && s_q.eer == 8'h00 && s_q.qer == 8'h00;
   endproperty
   a_cls: assert property (p_cls) else $error("clear status left state set");
   property p_ese_w;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_ESE_W |=> s_q.ese == $past(cmd_arg_i);
   endproperty
   a_ese_w: assert property (p_ese_w) else $error("enable write not loaded");
   property p_term;
      @(posedge clk_sys_i) disable iff (rst_i)
         rsp_valid_o && rsp_last_o |-> rsp_data_o == srcu_pkg::TERM_CHAR;
   endproperty
   a_term: assert property (p_term) else $error("last byte is not the terminator");
   property p_esr_q;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_ESR_Q && evt_set_i == 8'h00
         && !exec_err_i && !query_err_i |=> esr_o == 8'h00;
   endproperty
   a_esr_q: assert property (p_esr_q) else $error("event status not cleared by query");
   property p_opc;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_OPC |=> esr_o[srcu_pkg::ESR_OPC_BIT];
   endproperty
   a_opc: assert property (p_opc) else $error("operation complete bit not set");
   property p_opc_q;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_OPC_Q
         |=> s_q.sbuf[31:16] == {srcu_pkg::ASCII_ONE, srcu_pkg::TERM_CHAR} && s_q.len == 3'h2;
   endproperty
   a_opc_q: assert property (p_opc_q) else $error("operation complete query wrong");
   property p_wai;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_WAI |=> cmd_ready_o && s_q.sbuf == $past(s_q.sbuf);
   endproperty
   a_wai: assert property (p_wai) else $error("wait command stalled the unit");
   property p_tst;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_TST_Q
         |=> s_q.sbuf[31:16] == {srcu_pkg::ASCII_ZERO, srcu_pkg::TERM_CHAR};
   endproperty
   a_tst: assert property (p_tst) else $error("self test answer not zero");
   property p_trg;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_FORCE_TRG
         |=> trig_o == ($past(trig_src_i) != srcu_pkg::TRIG_SRC_MAN)
         ##1 (!trig_o || $past(cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_FORCE_TRG));
   endproperty
   a_trg: assert property (p_trg) else $error("forced trigger wrong");
   property p_srq;
      @(posedge clk_sys_i) disable iff (rst_i)
         srq_o == stb_o[srcu_pkg::STB_MSS_BIT] && stb_o[srcu_pkg::STB_ESB_BIT] == |(esr_o & s_q.ese);
   endproperty
   a_srq: assert property (p_srq) else $error("summary or service request mismatch");
   // register loads, read-clears and sequencing seen from the outputs and the state register fields
   property p_ist;
      @(posedge clk_sys_i) disable iff (rst_i)
         ist_o == |(stb_o & s_q.pre);
   endproperty
   a_ist: assert property (p_ist) else $error("individual status mismatch");
   property p_pre_w;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_PRE_W |=> s_q.pre == $past(cmd_arg_i);
   endproperty
   a_pre_w: assert property (p_pre_w) else $error("poll enable write not loaded");
   property p_sre_w;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_SRE_W |=> s_q.sre == $past(cmd_arg_i);
   endproperty
   a_sre_w: assert property (p_sre_w) else $error("service enable write not loaded");
   property p_exec_clr;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_EXEC_ERR_Q && !exec_err_i
         |=> s_q.eer == 8'h00;
   endproperty
   a_exec_clr: assert property (p_exec_clr) else $error("execution error not cleared by query");
   property p_query_clr;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_QUERY_ERR_Q && !query_err_i
         |=> s_q.qer == 8'h00;
   endproperty
   a_query_clr: assert property (p_query_clr) else $error("query error not cleared by query");
   property p_idn;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_IDN_Q
         |=> s_q.st == srcu_pkg::ST_ID && s_q.addr == 6'h00;
   endproperty
   a_idn: assert property (p_idn) else $error("identification text not started");
   property p_trg_src;
      @(posedge clk_sys_i) disable iff (rst_i)
         trig_o |-> $past(cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_FORCE_TRG
         && trig_src_i != srcu_pkg::TRIG_SRC_MAN);
   endproperty
   a_trg_src: assert property (p_trg_src) else $error("trigger without a forced trigger command");
   property p_busy;
      @(posedge clk_sys_i) disable iff (rst_i)
         cmd_valid_i && cmd_ready_o && cmd_code_i == srcu_pkg::CMD_STB_Q |=> !cmd_ready_o;
   endproperty
   a_busy: assert property (p_busy) else $error("command taken while a query is answered");
   property p_hold;
      @(posedge clk_sys_i) disable iff (rst_i)
         rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && rsp_data_o == $past(rsp_data_o)
         && rsp_last_o == $past(rsp_last_o);
   endproperty
   a_hold: assert property (p_hold) else $error("response byte dropped before it was taken");
endmodule // srcu_top
`default_nettype wire

// File: dv/srcu_host.sv
// Purpose: remote host controller model driving commands and collecting responses
// Assumes: one command at a time; requests change only at the falling edge
// Notes: slow mode toggles rsp_ready_o every cycle so the unit must hold bytes
`default_nettype none
module srcu_host (
   input wire logic clk_sys_i,
   input wire logic cmd_ready_i,
   input wire logic rsp_valid_i,
   input wire logic [7:0] rsp_data_i,
   input wire logic rsp_last_i,
   output logic cmd_valid_o,
   output logic [4:0] cmd_code_o,
   output logic [7:0] cmd_arg_o,
   output logic rsp_ready_o,
   output logic [7:0] n_timeout_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic slow;

   // idle host: nothing requested, nothing accepted
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = 5'h00;
      cmd_arg_o = 8'h00;
      rsp_ready_o = 1'b0;
      n_timeout_o = 8'h00;
      slow = 1'b0;
   end

   // hold the request until an edge sees ready, then release it
   task automatic send(input logic [4:0] code, input logic [7:0] arg);
      int i;
      logic rdy;
      @(negedge clk_sys_i);
      cmd_valid_o = 1'b1;
      cmd_code_o = code;
      cmd_arg_o = arg;
      for (i = 0; i < 100; i++) begin
         if (i > 0) @(negedge clk_sys_i);
         // ready read between edges is what the coming edge sees; at the edge it races
         rdy = cmd_ready_i;
         @(posedge clk_sys_i);
         if (rdy === 1'b1) break;
      end
      if (i == 100) n_timeout_o++;
      @(negedge clk_sys_i);
      cmd_valid_o = 1'b0;
      // released lines show a changed pattern so stale values are never trusted
      cmd_code_o = ~code;
      cmd_arg_o = ~arg;
   endtask

   // issue a query and gather bytes up to and including the terminator
   task automatic ask(input logic [4:0] code, output string s);
      int i;
      logic done;
      logic vld;
      logic lst;
      logic [7:0] dat;
      s = "";
      done = 1'b0;
      send(code, 8'h00);
      for (i = 0; i < 200 && !done; i++) begin
         if (i > 0) @(negedge clk_sys_i);
         rsp_ready_o = slow ? ~rsp_ready_o : 1'b1;
         // take the byte as it stands before the edge that moves it on
         vld = rsp_valid_i;
         dat = rsp_data_i;
         lst = rsp_last_i;
         @(posedge clk_sys_i);
         if (vld === 1'b1 && rsp_ready_o) begin
            s = $sformatf("%s%c", s, dat);
            done = (lst === 1'b1);
         end
      end
      if (!done) n_timeout_o++;
      @(negedge clk_sys_i);
      rsp_ready_o = 1'b0;
   endtask
endmodule // srcu_host
`default_nettype wire

// File: dv/srcu_top_tb.sv
// Purpose: self-checking bench of the status reporting command unit
// Assumes: host model issues commands; bench drives event and error inputs
// Notes: expected answers are worked out by hand from the register values set
`default_nettype none
module srcu_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys_i = 1'b0;
   logic rst_i, cmd_valid, cmd_ready, rsp_valid, rsp_last, rsp_ready, exec_err, query_err, trig, srq, ist;
   logic [4:0] cmd_code;
   logic [7:0] cmd_arg, rsp_data, evt_set, exec_num, query_num, esr, stb, n_timeout;
   logic [2:0] trig_src;
   int n_mismatch = 0;
   int check_count = 0;
   string s;

   // 50 MHz system clock
   always #10 clk_sys_i = ~clk_sys_i;

   srcu_top dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code),
      .cmd_arg_i(cmd_arg), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data),
      .rsp_last_o(rsp_last), .rsp_ready_i(rsp_ready), .evt_set_i(evt_set), .exec_err_i(exec_err),
      .exec_err_num_i(exec_num), .query_err_i(query_err), .query_err_num_i(query_num), .trig_src_i(trig_src),
      .trig_o(trig), .esr_o(esr), .stb_o(stb), .srq_o(srq), .ist_o(ist));

   srcu_host host_u (.clk_sys_i(clk_sys_i), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid),
      .rsp_data_i(rsp_data), .rsp_last_i(rsp_last), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_arg_o(cmd_arg), .rsp_ready_o(rsp_ready), .n_timeout_o(n_timeout));

   // compare helpers count every check and report misses at once
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chks(input string got, input string exp);
      check_count++;
      if (got != exp) begin
         n_mismatch++;
         $display("ERROR t=%0t response %s expected %s", $time, got, exp);
      end
   endtask

   // one-cycle error pulse; q selects the query error input
   task automatic err_pulse(input logic q, input logic [7:0] num);
      @(negedge clk_sys_i);
      query_err = q;
      exec_err = ~q;
      query_num = num;
      exec_num = num;
      @(negedge clk_sys_i);
      query_err = 1'b0;
      exec_err = 1'b0;
   endtask

   task automatic tally_and_finish();
      if (n_timeout !== 8'h00) n_mismatch++;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // main sequence: reset, then each status command in turn
   initial begin
      rst_i = 1'b1;
      evt_set = 8'h00;
      exec_err = 1'b0;
      query_err = 1'b0;
      exec_num = 8'h00;
      query_num = 8'h00;
      trig_src = 3'h0;
      repeat (10) @(negedge clk_sys_i);
      rst_i = 1'b0;
      chk8({7'h00, cmd_ready}, 8'h01, "ready after reset");
      chk8(esr, 8'h00, "esr after reset");
      $display("test reset done");
      host_u.send(srcu_pkg::CMD_OPC, 8'h00);
      chk8(esr, 8'h01, "opc bit");
      host_u.ask(srcu_pkg::CMD_OPC_Q, s);
      chks(s, "1\n");
      $display("test opc done");
      host_u.send(srcu_pkg::CMD_ESE_W, 8'h01);
      chk8(stb, 8'h20, "event summary");
      host_u.ask(srcu_pkg::CMD_ESE_Q, s);
      chks(s, "1\n");
      host_u.send(srcu_pkg::CMD_SRE_W, 8'hff);
      host_u.send(srcu_pkg::CMD_SRE_W, 8'h20);
      chk8({7'h00, srq}, 8'h01, "service request");
      host_u.ask(srcu_pkg::CMD_SRE_Q, s);
      chks(s, "32\n");
      host_u.ask(srcu_pkg::CMD_STB_Q, s);
      chks(s, "96\n");
      host_u.send(srcu_pkg::CMD_PRE_W, 8'h40);
      chk8({7'h00, ist}, 8'h01, "ist level");
      host_u.ask(srcu_pkg::CMD_PRE_Q, s);
      chks(s, "64\n");
      host_u.ask(srcu_pkg::CMD_IST_Q, s);
      chks(s, "1\n");
      $display("test enables done");
      host_u.ask(srcu_pkg::CMD_ESR_Q, s);
      chks(s, "1\n");
      chk8(esr, 8'h00, "esr cleared by read");
      chk8({7'h00, srq}, 8'h00, "service request dropped");
      chk8({7'h00, ist}, 8'h00, "ist level dropped");
      host_u.ask(srcu_pkg::CMD_IST_Q, s);
      chks(s, "0\n");
      $display("test event read done");
      err_pulse(1'b0, 8'hc8);
      chk8(esr, 8'h10, "exec error bit");
      host_u.ask(srcu_pkg::CMD_EXEC_ERR_Q, s);
      chks(s, "200\n");
      host_u.ask(srcu_pkg::CMD_EXEC_ERR_Q, s);
      chks(s, "0\n");
      err_pulse(1'b1, 8'h07);
      host_u.ask(srcu_pkg::CMD_QUERY_ERR_Q, s);
      chks(s, "7\n");
      host_u.ask(srcu_pkg::CMD_QUERY_ERR_Q, s);
      chks(s, "0\n");
      $display("test error numbers done");
      err_pulse(1'b0, 8'h05);
      err_pulse(1'b1, 8'h09);
      @(negedge clk_sys_i);
      evt_set = 8'h81;
      @(negedge clk_sys_i);
      evt_set = 8'h00;
      host_u.send(srcu_pkg::CMD_CLS, 8'h00);
      chk8(esr, 8'h00, "esr after clear");
      chk8(stb, 8'h00, "stb after clear");
      host_u.ask(srcu_pkg::CMD_EXEC_ERR_Q, s);
      chks(s, "0\n");
      host_u.ask(srcu_pkg::CMD_QUERY_ERR_Q, s);
      chks(s, "0\n");
      $display("test clear status done");
      host_u.send(srcu_pkg::CMD_WAI, 8'h00);
      chk8({7'h00, cmd_ready}, 8'h01, "wait is a no-op");
      chk8(esr, 8'h00, "wait leaves esr");
      host_u.slow = 1'b1;
      host_u.ask(srcu_pkg::CMD_TST_Q, s);
      chks(s, "0\n");
      host_u.ask(srcu_pkg::CMD_IDN_Q, s);
      chks(s, "ACMECO,WAVEGEN,0,1.00\n");
      host_u.slow = 1'b0;
      $display("test fixed answers done");
      host_u.send(srcu_pkg::CMD_FORCE_TRG, 8'h00);
      chk8({7'h00, trig}, 8'h01, "trigger pulse");
      @(negedge clk_sys_i);
      chk8({7'h00, trig}, 8'h00, "trigger one cycle");
      trig_src = srcu_pkg::TRIG_SRC_MAN;
      host_u.send(srcu_pkg::CMD_FORCE_TRG, 8'h00);
      chk8({7'h00, trig}, 8'h00, "manual source blocks trigger");
      host_u.send(5'h1f, 8'h00);
      chk8(esr, 8'h20, "unknown code flags command error");
      $display("test trigger done");
      tally_and_finish();
   end
endmodule // srcu_top_tb
`default_nettype wire
